/* hdl/msr_pkg.sv */
package state_reg_pkg;
    // register width and big-endian bit numbering (bit 0 is the msb)
    localparam int STATE_W = 32;
    localparam int STATE_TOP = STATE_W - 1;
    // printed bit numbers converted to vector positions
    localparam int POS_SLEEP_EN   = STATE_TOP - 13;
    localparam int POS_REMAP      = STATE_TOP - 14;
    localparam int POS_INTR_ORDER = STATE_TOP - 15;
    localparam int POS_EXT_EN     = STATE_TOP - 16;
    localparam int POS_USER       = STATE_TOP - 17;
    localparam int POS_ORDER      = 0;
    // reserved groups: full function bits 0 and 5..9 are saved,
    // partial function bits 1..4 and 10..12 are not
    localparam logic [31:0] FULL_RSVD_MASK = 32'h87c0_0000;
    localparam logic [31:0] PART_RSVD_MASK = 32'h7838_0000;
    // reset values
    localparam logic [31:0] STATE_RST = 32'h0000_0000;
    localparam logic [31:0] SAVE_RST  = 32'h0000_0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    // register offsets on the bus (byte addresses)
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATE  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SAVE   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    // status register bit positions
    localparam int ST_SLEEP   = 0;
    localparam int ST_PENDING = 1;
    localparam int ST_EXTTAKE = 2;
    localparam int ST_PFAULT  = 3;
    localparam int ST_DYNPWR  = 4;
    // general and shadow register file sizes
    localparam int GPR_N    = 32;
    localparam int GPR_IW   = 5;
    localparam int SHADOW_N = 4;
    localparam logic [GPR_IW-1:0] SHADOW_LIMIT = 5'h04;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
endpackage

/* hdl/machine_state_reg_upper.sv */
`timescale 1ns/100ps
module machine_state_reg_upper
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // avalon-mm slave
    input  wire logic [state_reg_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    // interrupt entry and return from the core
    input  wire logic                  intr_take,
    input  wire logic                  intr_tlb_miss,
    input  wire logic                  rfi_exec,
    input  wire logic                  ctx_sync,
    // interrupt sources and instruction class
    input  wire logic                  ext_irq,
    input  wire logic                  smi_irq,
    input  wire logic                  dec_irq,
    input  wire logic                  instr_is_super,
    input  wire logic                  dynamic_power_mgmt,
    // general register port
    input  wire logic [state_reg_pkg::GPR_IW-1:0] gpr_idx,
    input  wire logic                  gpr_we,
    input  wire logic [31:0]           gpr_wdata,
    output logic [31:0]                gpr_rdata,
    // state outputs
    output logic [31:0]                machine_state_reg,
    output logic [31:0]                save_restore_reg1,
    output logic                       sleep_modes_enable,
    output logic                       dynpwr_active,
    output logic                       ext_intr_take,
    output logic                       priv_fault
);
    import state_reg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state declarations
    bus_state_t  bus_r, bus_nxt;          // bus slave handshake
    logic        wait_r, wait_nxt;        // registered waitrequest
    logic [31:0] rdata_r, rdata_nxt;      // registered read data
    logic [31:0] state_r, state_nxt;      // machine state register
    logic [31:0] save_r, save_nxt;        // save/restore register 1
    logic        sleep_r, sleep_nxt;      // power modes in force
    logic        pend_r, pend_nxt;        // power bit awaits sync
    logic        dynpwr_r, dynpwr_nxt;    // dynamic power follower
    logic        take_r, take_nxt;        // external class taken
    logic        pfault_r, pfault_nxt;    // privileged use in user
    logic [31:0] gpr_r [GPR_N];           // architected registers
    logic [31:0] shadow_r [SHADOW_N];     // remap scratch registers
    logic [31:0] gprd_r, gprd_nxt;        // registered gpr read
    logic        bus_wr;                  // write accepted this edge
    logic        remap;                   // remap mode active

    // merge write data under byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // value saved on interrupt entry
    // drop partial-function bits
    function automatic logic [31:0] save_val(input logic [31:0] m);
        return m & ~PART_RSVD_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, then a single ready cycle
    always_comb begin
        bus_nxt   = BUS_IDLE;
        rdata_nxt = rdata_r;
        unique case (bus_r)
            BUS_IDLE: begin
                // capture read data while the request is held
                if (avs_read || avs_write) begin
                    bus_nxt = BUS_ACK;
                    if (avs_address == OFS_STATE) begin
                        rdata_nxt = state_r;
                    end else if (avs_address == OFS_SAVE) begin
                        rdata_nxt = save_r;
                    end else if (avs_address == OFS_STATUS) begin
                        rdata_nxt = DATA_ZERO;
                        rdata_nxt[ST_SLEEP]   = sleep_r;
                        rdata_nxt[ST_PENDING] = pend_r;
                        rdata_nxt[ST_EXTTAKE] = take_r;
                        rdata_nxt[ST_PFAULT]  = pfault_r;
                        rdata_nxt[ST_DYNPWR]  = dynpwr_r;
                    end else begin
                        // unmapped offsets read as zero
                        rdata_nxt = DATA_ZERO;
                    end
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
        // ready flag registered so the pin comes straight from a flop
        wait_nxt = (bus_nxt != BUS_ACK);
    end

    // writes take effect at the edge where waitrequest is low
    assign bus_wr = (bus_r == BUS_ACK) && avs_write;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_r   <= BUS_IDLE;
            wait_r  <= 1'b1;
            rdata_r <= DATA_ZERO;
        end else begin
            bus_r   <= bus_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register and save register updates
    // priority: interrupt entry, then return, then software write
    always_comb begin
        logic [31:0] wv;
        wv         = merge_be(state_r, avs_writedata, avs_byteenable);
        state_nxt  = state_r;
        save_nxt   = save_r;
        if (intr_take) begin
            save_nxt = save_val(state_r);
            state_nxt[POS_ORDER] = state_r[POS_INTR_ORDER];
            if (intr_tlb_miss) begin
                state_nxt[POS_REMAP] = 1'b1;
            end
        end else if (rfi_exec) begin
            state_nxt = save_r;
            state_nxt[POS_REMAP] = 1'b0;
        end else if (bus_wr && avs_address == OFS_STATE) begin
            if (wv[POS_SLEEP_EN] != state_r[POS_SLEEP_EN]) begin
                state_nxt[POS_SLEEP_EN] = wv[POS_SLEEP_EN];
            end else begin
                state_nxt = wv;
            end
        end else if (bus_wr && avs_address == OFS_SAVE) begin
            save_nxt = wv;
        end
    end

    // 32-bit word, printed bit 0 is the msb
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= STATE_RST;
            save_r  <= SAVE_RST;
        end else begin
            state_r <= state_nxt;
            save_r  <= save_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power mode, interrupt gating and privilege checks
    always_comb begin
        pend_nxt  = pend_r;
        sleep_nxt = sleep_r;
        // new power bit waits for sync
        if (state_nxt[POS_SLEEP_EN] != state_r[POS_SLEEP_EN]) begin
            pend_nxt = 1'b1;
        end else if (ctx_sync) begin
            pend_nxt = 1'b0;
        end
        if (ctx_sync) begin
            sleep_nxt = state_r[POS_SLEEP_EN];
        end
        dynpwr_nxt = dynamic_power_mgmt;
        take_nxt = state_r[POS_EXT_EN] && (ext_irq || smi_irq || dec_irq);
        pfault_nxt = state_r[POS_USER] && instr_is_super;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r   <= 1'b0;
            sleep_r  <= 1'b0;
            dynpwr_r <= 1'b0;
            take_r   <= 1'b0;
            pfault_r <= 1'b0;
        end else begin
            pend_r   <= pend_nxt;
            sleep_r  <= sleep_nxt;
            dynpwr_r <= dynpwr_nxt;
            take_r   <= take_nxt;
            pfault_r <= pfault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register file with shadow remap
    // the memory has no reset; only the read register does
    assign remap = state_r[POS_REMAP];

    always_comb begin
        // high indices keep plain access, no promise
        if (remap && gpr_idx < SHADOW_LIMIT) begin
            gprd_nxt = shadow_r[gpr_idx[1:0]];
        end else begin
            gprd_nxt = gpr_r[gpr_idx];
        end
    end

    always_ff @(posedge mclk) begin
        if (gpr_we && remap && gpr_idx < SHADOW_LIMIT) begin
            shadow_r[gpr_idx[1:0]] <= gpr_wdata;
        end else if (gpr_we) begin
            gpr_r[gpr_idx] <= gpr_wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gprd_r <= DATA_ZERO;
        end else begin
            gprd_r <= gprd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    assign avs_readdata       = rdata_r;
    assign avs_waitrequest    = wait_r;
    assign machine_state_reg  = state_r;
    assign save_restore_reg1  = save_r;
    assign sleep_modes_enable = sleep_r;
    assign dynpwr_active      = dynpwr_r;
    assign ext_intr_take      = take_r;
    assign priv_fault         = pfault_r;
    assign gpr_rdata          = gprd_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_SAVE_FULL: assert property (
        intr_take |=> (save_r & FULL_RSVD_MASK) ==
                      ($past(state_r) & FULL_RSVD_MASK))
        else $error("full reserved bits not saved");
    AST_DROP_PART: assert property (
        intr_take |=> (save_r & PART_RSVD_MASK) == DATA_ZERO)
        else $error("partial reserved bits saved");
    AST_SLEEP_SYNC: assert property (
        ctx_sync |=> sleep_modes_enable == $past(state_r[POS_SLEEP_EN]))
        else $error("power mode not taken at sync");
    AST_DYNPWR_FREE: assert property (
        dynpwr_active == $past(dynamic_power_mgmt))
        else $error("dynamic power management disturbed");
    AST_SLEEP_EN_ALONE: assert property (
        (!intr_take && !rfi_exec &&
         state_nxt[POS_SLEEP_EN] != state_r[POS_SLEEP_EN]) |=>
        (state_r ^ $past(state_r)) == (32'h1 << POS_SLEEP_EN))
        else $error("power write changed other bits");
    AST_SHADOW_KEEP: assert property (
        (remap && gpr_we && gpr_idx < SHADOW_LIMIT) |=>
        gpr_r[$past(gpr_idx)] == $past(gpr_r[gpr_idx]))
        else $error("original register changed in remap");
    AST_MISS_SET: assert property (
        (intr_take && intr_tlb_miss) |=> state_r[POS_REMAP])
        else $error("remap not set on miss");
    AST_RFI_CLR: assert property (
        (rfi_exec && !intr_take) |=> !state_r[POS_REMAP])
        else $error("remap not cleared on return");
    AST_ORDER_COPY: assert property (
        intr_take |=> state_r[POS_ORDER] == $past(state_r[POS_INTR_ORDER]))
        else $error("byte order not copied");
    AST_EXT_GATE: assert property (
        !state_r[POS_EXT_EN] |=> !ext_intr_take)
        else $error("external class taken while disabled");
    AST_USER_FAULT: assert property (
        priv_fault ==
            ($past(state_r[POS_USER]) && $past(instr_is_super)))
        else $error("privilege check wrong");
    AST_BUS_ONE: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("ready held longer than one cycle");

endmodule

/* bench/machine_state_reg_upper_tb.sv */
`timescale 1ns/100ps
module machine_state_reg_upper_tb;
    import state_reg_pkg::*;
    // clock, reset and bus
    logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q, v, part_m;
    // core events: intr_take, intr_tlb_miss, rfi_exec, ctx_sync
    logic [3:0]  evt;
    // external class sources: ext, smi, dec
    logic [2:0]  src;
    logic        instr_is_super, dynamic_power_mgmt, gpr_we;
    logic [4:0]  gpr_idx;
    logic [31:0] gpr_wdata, gpr_rdata, machine_state_reg, save_restore_reg1;
    logic        sleep_modes_enable, dynpwr_active, ext_intr_take, priv_fault;
    int          n_fail, compares, cyc;
    ////////////////////////////////////////////////////////////////////////
    machine_state_reg_upper dut_u (.mclk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .intr_take(evt[3]), .intr_tlb_miss(evt[2]),
        .rfi_exec(evt[1]), .ctx_sync(evt[0]), .ext_irq(src[2]),
        .smi_irq(src[1]), .dec_irq(src[0]), .instr_is_super,
        .dynamic_power_mgmt, .gpr_idx, .gpr_we, .gpr_wdata, .gpr_rdata,
        .machine_state_reg, .save_restore_reg1, .sleep_modes_enable,
        .dynpwr_active, .ext_intr_take, .priv_fault);
    ////////////////////////////////////////////////////////////////////////
    // printed bit number to vector bit, bit 0 is the msb
    function logic [31:0] db(input int n);
        return 32'h8000_0000 >> n;
    endfunction
    // one compare for every value, flags widened to a word
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // let one edge land, look at the settled outputs
    task tick;
        @(posedge mclk);
        @(negedge mclk);
    endtask
    // avalon cycle, held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // one-cycle core event pulse
    task ev(input logic [3:0] e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= 4'h0;
        @(negedge mclk);
    endtask
    task gpr_wr(input logic [4:0] i, input logic [31:0] d);
        @(posedge mclk);
        gpr_idx   <= i;
        gpr_wdata <= d;
        gpr_we    <= 1'b1;
        @(posedge mclk);
        gpr_we <= 1'b0;
    endtask
    // read port is registered, one cycle late
    task gpr_rd(input logic [4:0] i);
        @(posedge mclk);
        gpr_idx <= i;
        tick;
        q = gpr_rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_bus;
        bus(1'b0, OFS_STATE, 32'h0);
        chk("state reset", 32'h0, q);
        v = db(16) | db(17);
        bus(1'b1, OFS_STATE, v);
        bus(1'b0, OFS_STATE, 32'h0);
        chk("state readback", v, q);
        // lanes left out of a write keep their old byte
        avs_byteenable <= 4'hd;
        bus(1'b1, OFS_STATE, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b0, OFS_STATE, 32'h0);
        chk("lanes kept", v, q);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, q);
        // every external class source on its own
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            src <= 3'b100 >> i;
            tick;
            chk("ext take", 32'h1, {31'h0, ext_intr_take});
        end
        @(posedge mclk);
        instr_is_super <= 1'b1;
        tick;
        chk("priv fault", 32'h1, {31'h0, priv_fault});
        bus(1'b1, OFS_STATE, 32'h0);
        tick;
        chk("ext masked", 32'h0, {31'h0, ext_intr_take});
        chk("priv clear", 32'h0, {31'h0, priv_fault});
        @(posedge mclk);
        src            <= 3'h0;
        instr_is_super <= 1'b0;
        $display("t_bus done");
    endtask
    task t_intr;
        // every reserved bit set, byte-order select set, mode clear
        v = ~(db(13) | db(14) | db(31));
        bus(1'b1, OFS_STATE, v);
        ev(4'b1000);
        chk("save plain", v & ~part_m, save_restore_reg1);
        chk("state plain", v | db(31), machine_state_reg);
        v = (v & ~db(15)) | db(31);
        bus(1'b1, OFS_STATE, v);
        ev(4'b1100);
        chk("save miss", v & ~part_m, save_restore_reg1);
        chk("state miss", (v & ~db(31)) | db(14), machine_state_reg);
        // saved word carries the remap bit, so the return must drop it
        bus(1'b1, OFS_SAVE, (v & ~part_m) | db(14));
        ev(4'b0010);
        chk("state rfi", v & ~part_m, machine_state_reg);
        bus(1'b1, OFS_STATE, 32'h0);
        $display("t_intr done");
    endtask
    task t_remap;
        gpr_wr(5'h00, 32'h1111_1111);
        ev(4'b1100);
        gpr_wr(5'h00, 32'haaaa_aaaa);
        gpr_rd(5'h00);
        chk("shadow read", 32'haaaa_aaaa, q);
        ev(4'b0010);
        gpr_rd(5'h00);
        chk("original kept", 32'h1111_1111, q);
        $display("t_remap done");
    endtask
    task t_power;
        // a power-bit change carries no other bit along
        bus(1'b1, OFS_STATE, db(13) | db(16));
        bus(1'b0, OFS_STATE, 32'h0);
        chk("power alone", db(13), q);
        chk("no sleep yet", 32'h0, {31'h0, sleep_modes_enable});
        // only the pending flag is up until the sync arrives
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("pending status", 32'h1 << ST_PENDING, q);
        @(posedge mclk);
        dynamic_power_mgmt <= 1'b1;
        tick;
        chk("dynpwr on", 32'h1, {31'h0, dynpwr_active});
        ev(4'b0001);
        chk("sleep on", 32'h1, {31'h0, sleep_modes_enable});
        bus(1'b1, OFS_STATE, 32'h0);
        ev(4'b0001);
        chk("sleep off", 32'h0, {31'h0, sleep_modes_enable});
        chk("dynpwr kept", 32'h1, {31'h0, dynpwr_active});
        @(posedge mclk);
        dynamic_power_mgmt <= 1'b0;
        tick;
        chk("dynpwr off", 32'h0, {31'h0, dynpwr_active});
        $display("t_power done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // free-running clock, 20 ns period
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    // hang guard, far above the fewer than a hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        {rst_n, avs_read, avs_write, evt, src} = '0;
        {instr_is_super, dynamic_power_mgmt, gpr_we} = '0;
        {avs_address, avs_writedata, gpr_idx, gpr_wdata} = '0;
        avs_byteenable = 4'hf;
        part_m = db(1) | db(2) | db(3) | db(4) | db(10) | db(11) | db(12);
        repeat (3) @(posedge mclk);
        chk("wait in reset", 32'h1, {31'h0, avs_waitrequest});
        rst_n <= 1'b1;
        t_bus;
        t_intr;
        t_remap;
        t_power;
        complete_run;
    end
endmodule
